// ---- pkg/flash_seq_pkg.sv ----
// Contract
// - 32 sectors, 16 rows, 16 words
// - Little endian contiguous byte mapping
// - Status covers whole word per read
// - Reads wait while array busy (the code answers reads during erase/program with an error instead)
// - Access during erase/program gets error
// - Page-register write fills page buffer only
// - Master sets mode bits before write
// - Posted write when idle, else wait
// - Replay last write; replay bit reads zero
// - No protection error from controller
// - Fixed lock bits, firmware sectors locked
// - All protected at reset; bit0 sets
// - Sector selections latch, cleared after erase
// - Erase sets region to ones
// - Software loads count, enables, writes erase
// - Array ready low during erase/program
// - Erase end: done flag, enable bar, erase select
// - Program clears bits where buffer zero
// - Software never reprograms a programmed word
// - Preset fills buffer ones, then cleared
// - Software loads count, writes program pattern
// - Program end: done flag, enable bar set
package flash_seq_pkg;
	localparam int SECTORS = 32;
	localparam int ROWS_PER_SECTOR = 16;
	localparam int WORDS_PER_ROW = 16;
	localparam int DATA_W = 32;
	localparam int WORDS_PER_SECTOR = ROWS_PER_SECTOR * WORDS_PER_ROW;
	localparam int WORDS = SECTORS * WORDS_PER_SECTOR;
	localparam int WORD_AW = $clog2(WORDS);
	localparam int BYTE_LSB = 2;
	localparam int BYTE_AW = WORD_AW + BYTE_LSB;
	localparam int ROW_LSB = $clog2(WORDS_PER_ROW);
	localparam int SEC_LSB = $clog2(WORDS_PER_SECTOR);
	localparam int SEC_W = WORD_AW - SEC_LSB;

	localparam logic [BYTE_AW-1:0] REG_CTRL = 15'h0000;
	localparam logic [BYTE_AW-1:0] REG_TIMING = 15'h0004;
	localparam logic [BYTE_AW-1:0] REG_STATUS = 15'h0008;

	localparam int CTRL_W = 7;
	localparam int CTRL_CS = 0;
	localparam int CTRL_WR_RD_EN = 1;
	localparam int CTRL_WR_EN_BAR = 2;
	localparam int CTRL_WR_PROT_BAR = 3;
	localparam int CTRL_PAGE_ERASE = 4;
	localparam int CTRL_REPLAY = 5;
	localparam int CTRL_PRESET = 6;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h0C;

	// Mode code is {write_protect_bar, write_enable_bar, write_read_enable, chip_select_bit}
	localparam logic [3:0] MODE_PAGE = 4'h7;
	localparam logic [3:0] MODE_SELECT = 4'hD;
	localparam logic [3:0] MODE_PROTECT = 4'hF;
	localparam logic [3:0] MODE_ERASE = 4'h9;
	localparam logic [3:0] MODE_PROGRAM = 4'hB;

	localparam int CNT_W = 16;
	localparam int TIMING_EN_BIT = 31;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam int STATUS_READY_BIT = 0;
	localparam int STATUS_DONE_BIT = 1;

	localparam logic [SECTORS-1:0] PROT_RESET = 32'hFFFFFFFF;
	localparam logic [SECTORS-1:0] LOCK_DEFAULT = 32'hC0000000;

	localparam logic [2:0] HREG_ADDR = 3'h0;
	localparam logic [2:0] HREG_WDATA = 3'h1;
	localparam logic [2:0] HREG_CMD = 3'h2;
	localparam logic [2:0] HREG_STATUS = 3'h3;
	localparam logic [2:0] HREG_RDATA = 3'h4;
	localparam int CMD_GO_BIT = 0;
	localparam int CMD_WRITE_BIT = 1;
	localparam int HADDR_REG_BIT = 16;
	localparam int HSTAT_BUSY = 0;
	localparam int HSTAT_ERR = 1;

	typedef enum logic [1:0] {DEV_IDLE, DEV_MOVE, DEV_HV} dev_state_type;
	typedef enum logic {HOST_IDLE, HOST_REQ} host_state_type;
endpackage : flash_seq_pkg

// ---- pkg/flash_bus_if.sv ----
`timescale 1ns/1ps
interface flash_bus_if;
	import flash_seq_pkg::*;
	logic req;
	logic wr;
	logic reg_sel;
	logic [BYTE_AW-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic done;
	logic err;
	logic [DATA_W-1:0] rdata;
	modport device (input req, wr, reg_sel, addr, wdata, output done, err, rdata);
	modport host (output req, wr, reg_sel, addr, wdata, input done, err, rdata);
endinterface : flash_bus_if

// ---- logic/flash_device.sv ----
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module flash_device import flash_seq_pkg::*; #(
	parameter logic [SECTORS-1:0] LOCK_MASK = LOCK_DEFAULT
) (
	input wire logic clk,
	input wire logic reset,
	flash_bus_if.device bus
);
	typedef struct packed {
		dev_state_type state;
		logic done;
		logic err;
		logic [DATA_W-1:0] rdata;
		logic [CTRL_W-1:0] ctrl;
		logic [CNT_W-1:0] count;
		logic t_en;
		logic hv_done;
		logic [CNT_W-1:0] hv_cnt;
		logic hv_prog;
		logic [WORD_AW-1:0] last_addr;
		logic [DATA_W-1:0] last_data;
		logic [SECTORS-1:0] sel;
		logic [SECTORS-1:0] prot;
		logic [SECTORS-1:0] lock;
		logic [WORDS_PER_ROW-1:0][DATA_W-1:0] page;
	} dev_type;

	dev_type s;
	dev_type next_s;
	logic [DATA_W-1:0] mem [WORDS];
	logic [DATA_W-1:0] mem_word;
	logic erase_go;
	logic prog_go;
	logic take;
	logic [3:0] mode;
	logic [SEC_W-1:0] last_sec;
	logic [SECTORS-1:0] writable;
	logic [SECTORS-1:0] erase_sec;

	assign mem_word = mem[bus.addr[BYTE_AW-1:BYTE_LSB]];
	assign last_sec = s.last_addr[WORD_AW-1:SEC_LSB];
	assign writable = ~s.prot & ~s.lock;
	assign erase_sec = (s.sel | (SECTORS'(1) << last_sec)) & writable;
	assign bus.done = s.done;
	assign bus.err = s.err;
	assign bus.rdata = s.rdata;

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		next_s.err = 1'b0;
		erase_go = 1'b0;
		prog_go = 1'b0;
		mode = {s.ctrl[CTRL_WR_PROT_BAR], s.ctrl[CTRL_WR_EN_BAR], s.ctrl[CTRL_WR_RD_EN],
			s.ctrl[CTRL_CS]};
		take = bus.req && !s.done && s.state != DEV_MOVE;
		if (take) begin
			next_s.done = 1'b1;
			if (bus.reg_sel) begin
				if (bus.wr) begin
					case (bus.addr)
						REG_CTRL: begin
							// Control is frozen during a pulse so the mode cannot shift under it
							if (s.state == DEV_IDLE) begin
								next_s.ctrl = bus.wdata[CTRL_W-1:0];
								next_s.ctrl[CTRL_REPLAY] = 1'b0;
								if (bus.wdata[CTRL_REPLAY]) begin
									next_s.state = DEV_MOVE;
								end else if (s.t_en && bus.wdata[CTRL_WR_PROT_BAR]
										&& !bus.wdata[CTRL_WR_EN_BAR]
										&& bus.wdata[CTRL_CS]) begin
									next_s.state = DEV_HV;
									next_s.hv_cnt = s.count;
									next_s.hv_prog = bus.wdata[CTRL_WR_RD_EN];
								end
							end
						end
						REG_TIMING: begin
							next_s.count = bus.wdata[CNT_W-1:0];
							next_s.t_en = bus.wdata[TIMING_EN_BIT];
						end
						REG_STATUS: begin
							if (bus.wdata[STATUS_DONE_BIT]) begin
								next_s.hv_done = 1'b0;
							end
						end
						default: ;
					endcase
				end else begin
					next_s.rdata = '0;
					case (bus.addr)
						REG_CTRL: next_s.rdata[CTRL_W-1:0] = s.ctrl;
						REG_TIMING: begin
							next_s.rdata[CNT_W-1:0] = s.count;
							next_s.rdata[TIMING_EN_BIT] = s.t_en;
						end
						REG_STATUS: begin
							next_s.rdata[STATUS_READY_BIT] = s.state != DEV_HV;
							next_s.rdata[STATUS_DONE_BIT] = s.hv_done;
						end
						default: ;
					endcase
				end
			end else if (s.state == DEV_HV) begin
				next_s.err = 1'b1;
			end else if (bus.wr) begin
				next_s.last_addr = bus.addr[BYTE_AW-1:BYTE_LSB];
				next_s.last_data = bus.wdata;
				next_s.state = DEV_MOVE;
			end else if (mode == MODE_PAGE || mode == MODE_SELECT || mode == MODE_PROTECT) begin
				next_s.err = 1'b1;
			end else begin
				next_s.rdata = mem_word;
			end
		end
		case (s.state)
			DEV_MOVE: begin
				next_s.state = DEV_IDLE;
				case (mode)
					MODE_PAGE: next_s.page[s.last_addr[ROW_LSB-1:0]] = s.last_data;
					MODE_SELECT: next_s.sel[last_sec] = 1'b1;
					MODE_PROTECT: next_s.prot[last_sec] = s.last_data[0];
					default: ;
				endcase
			end
			DEV_HV: begin
				if (s.hv_cnt <= CNT_ONE) begin
					next_s.state = DEV_IDLE;
					next_s.hv_done = 1'b1;
					next_s.ctrl[CTRL_WR_EN_BAR] = 1'b1;
					if (s.hv_prog) begin
						prog_go = 1'b1;
					end else begin
						erase_go = 1'b1;
						next_s.ctrl[CTRL_PAGE_ERASE] = 1'b0;
						next_s.sel = '0;
					end
				end else begin
					next_s.hv_cnt = s.hv_cnt - CNT_ONE;
				end
			end
			default: ;
		endcase
		if (s.ctrl[CTRL_PRESET]) begin
			next_s.page = '1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s <= '0;
			s.state <= DEV_IDLE;
			s.ctrl <= CTRL_RESET;
			s.prot <= PROT_RESET;
			s.lock <= LOCK_MASK;
		end else begin
			s <= next_s;
		end
	end

	// One-cycle bulk update trades area for a simple model of the high-voltage step
	always_ff @(posedge clk) begin
		if (erase_go) begin
			for (int i = 0; i < WORDS; i++) begin
				if (erase_sec[i / WORDS_PER_SECTOR] && (!s.ctrl[CTRL_PAGE_ERASE]
						|| (i / WORDS_PER_ROW) == int'(s.last_addr[WORD_AW-1:ROW_LSB]))) begin
					mem[i] <= '1;
				end
			end
		end
		if (prog_go && writable[last_sec]) begin
			for (int w = 0; w < WORDS_PER_ROW; w++) begin
				mem[{s.last_addr[WORD_AW-1:ROW_LSB], ROW_LSB'(w)}] <=
					mem[{s.last_addr[WORD_AW-1:ROW_LSB], ROW_LSB'(w)}] & s.page[w];
			end
		end
	end
endmodule : flash_device

// ---- logic/flash_host.sv ----
`timescale 1ns/1ps
module flash_host import flash_seq_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic [2:0] av_address,
	input wire logic av_read,
	input wire logic av_write,
	input wire logic [DATA_W-1:0] av_writedata,
	input wire logic [3:0] av_byteenable,
	output logic [DATA_W-1:0] av_readdata,
	output logic av_waitrequest,
	flash_bus_if.host bus
);
	typedef struct packed {
		host_state_type state;
		logic waitreq;
		logic [DATA_W-1:0] readdata;
		logic [DATA_W-1:0] addr_reg;
		logic [DATA_W-1:0] wdata_reg;
		logic [DATA_W-1:0] rdata_reg;
		logic busy;
		logic err;
		logic req;
		logic wr;
		logic reg_sel;
		logic [BYTE_AW-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} host_type;

	host_type s;
	host_type next_s;
	logic access;

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
			input logic [DATA_W-1:0] wd, input logic [3:0] be);
		logic [DATA_W-1:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	assign av_readdata = s.readdata;
	assign av_waitrequest = s.waitreq;
	assign bus.req = s.req;
	assign bus.wr = s.wr;
	assign bus.reg_sel = s.reg_sel;
	assign bus.addr = s.addr;
	assign bus.wdata = s.wdata;

	always_comb begin
		next_s = s;
		// Answer one cycle after the request is seen
		access = (av_read || av_write) && s.waitreq;
		next_s.waitreq = !access;
		if (access && av_write) begin
			case (av_address)
				HREG_ADDR: next_s.addr_reg = merge(s.addr_reg, av_writedata, av_byteenable);
				HREG_WDATA: next_s.wdata_reg = merge(s.wdata_reg, av_writedata, av_byteenable);
				HREG_CMD: begin
					// mode writes pass as control transfers
					if (av_byteenable[0] && av_writedata[CMD_GO_BIT] && s.state == HOST_IDLE) begin
						next_s.state = HOST_REQ;
						next_s.req = 1'b1;
						next_s.busy = 1'b1;
						next_s.wr = av_writedata[CMD_WRITE_BIT];
						next_s.reg_sel = s.addr_reg[HADDR_REG_BIT];
						next_s.addr = s.addr_reg[BYTE_AW-1:0];
						next_s.wdata = s.wdata_reg;
					end
				end
				default: ;
			endcase
		end
		if (access && av_read) begin
			next_s.readdata = '0;
			case (av_address)
				HREG_ADDR: next_s.readdata = s.addr_reg;
				HREG_WDATA: next_s.readdata = s.wdata_reg;
				HREG_STATUS: begin
					next_s.readdata[HSTAT_BUSY] = s.busy;
					next_s.readdata[HSTAT_ERR] = s.err;
				end
				HREG_RDATA: next_s.readdata = s.rdata_reg;
				default: ;
			endcase
		end
		case (s.state)
			HOST_REQ: begin
				// Request held until the device answers
				if (bus.done) begin
					next_s.state = HOST_IDLE;
					next_s.req = 1'b0;
					next_s.busy = 1'b0;
					next_s.err = bus.err;
					next_s.rdata_reg = bus.rdata;
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s <= '0;
			s.state <= HOST_IDLE;
			s.waitreq <= 1'b1;
		end else begin
			s <= next_s;
		end
	end
endmodule : flash_host

// ---- dv/flash_seq_chk.sv ----
`timescale 1ns/1ps
module flash_seq_chk import flash_seq_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic req,
	input wire logic wr,
	input wire logic reg_sel,
	input wire logic [BYTE_AW-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic done,
	input wire logic err,
	input wire logic [DATA_W-1:0] rdata
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_done_pulse; done |=> !done; endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done held too long");

	property p_err_with_done; err |-> done; endproperty
	a_err_with_done: assert property (p_err_with_done) else $error("err without done");

	property p_req_answer; $rose(req) |-> ##[1:3] done; endproperty
	a_req_answer: assert property (p_req_answer) else $error("request not answered");

	property p_req_hold;
		req && !done |=> req && $stable(addr) && $stable(wr) && $stable(wdata);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request changed early");

	property p_req_drop; done |=> !req; endproperty
	a_req_drop: assert property (p_req_drop) else $error("req kept after done");

	property p_done_needs_req; done |-> req; endproperty
	a_done_needs_req: assert property (p_done_needs_req) else $error("done with no req");

	property p_rdata_hold; !done |-> $stable(rdata); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved alone");

	property p_replay_zero;
		done && reg_sel && !wr && addr == REG_CTRL |-> !rdata[CTRL_REPLAY];
	endproperty
	a_replay_zero: assert property (p_replay_zero) else $error("replay bit read one");
endmodule : flash_seq_chk

// ---- dv/flash_program_erase_sequencer_tb.sv ----
`timescale 1ns/1ps
module flash_program_erase_sequencer_tb;
	import flash_seq_pkg::*;
	logic clk, reset, av_read, av_write, e, av_waitrequest;
	logic [2:0] av_address;
	logic [DATA_W-1:0] av_writedata, av_readdata, q;
	// Model of the page buffer contents
	logic [DATA_W-1:0] pb [WORDS_PER_ROW];
	int n_fail, n_checks, s, r, r2, w, i, k;
	flash_bus_if lb();
	flash_host i_flash_host(.clk(clk), .reset(reset), .av_address(av_address),
		.av_read(av_read), .av_write(av_write), .av_writedata(av_writedata),
		.av_byteenable(4'hF), .av_readdata(av_readdata),
		.av_waitrequest(av_waitrequest), .bus(lb));
	flash_device i_flash_device(.clk(clk), .reset(reset), .bus(lb));
	flash_seq_chk i_flash_seq_chk(.clk(clk), .reset(reset), .req(lb.req), .wr(lb.wr),
		.reg_sel(lb.reg_sel), .addr(lb.addr), .wdata(lb.wdata), .done(lb.done),
		.err(lb.err), .rdata(lb.rdata));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	task chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task av(input logic [2:0] a, input logic wn, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] rd);
		int j;
		@(posedge clk);
		av_address <= a;
		av_write <= wn;
		av_read <= !wn;
		av_writedata <= d;
		for (j = 0; j < 50; j++) begin
			@(posedge clk);
			if (av_waitrequest === 1'b0) break;
		end
		rd = av_readdata;
		av_read <= 1'b0;
		av_write <= 1'b0;
		if (j == 50) begin
			n_fail++;
			tally_and_finish();
		end
	endtask : av

	// One link transfer through the host's command registers
	task lk(input logic rs, input logic [BYTE_AW-1:0] a, input logic wn,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd, output logic er);
		logic [DATA_W-1:0] st;
		int j;
		av(HREG_ADDR, 1'b1, {15'h0000, rs, 1'b0, a}, st);
		av(HREG_WDATA, 1'b1, d, st);
		av(HREG_CMD, 1'b1, {30'h00000000, wn, 1'b1}, st);
		for (j = 0; j < 20; j++) begin
			av(HREG_STATUS, 1'b0, 32'h00000000, st);
			if (st[HSTAT_BUSY] === 1'b0) break;
		end
		if (j == 20) begin
			n_fail++;
			tally_and_finish();
		end
		av(HREG_RDATA, 1'b0, 32'h00000000, rd);
		er = st[HSTAT_ERR];
	endtask : lk

	task wait_ready;
		int j;
		for (j = 0; j < 40; j++) begin
			lk(1'b1, REG_STATUS, 1'b0, 32'h00000000, q, e);
			if (q[STATUS_READY_BIT] === 1'b1) break;
		end
		if (j == 40) begin
			n_fail++;
			tally_and_finish();
		end
	endtask : wait_ready

	function automatic logic [BYTE_AW-1:0] wa(int sc, int rw, int wd);
		return BYTE_AW'((sc * WORDS_PER_SECTOR + rw * WORDS_PER_ROW + wd) * 4);
	endfunction : wa

	task pulse(input logic [DATA_W-1:0] mode);
		lk(1'b1, REG_TIMING, 1'b1, 32'h80000000 + $urandom_range(100, 60), q, e);
		lk(1'b1, REG_CTRL, 1'b1, mode, q, e);
	endtask : pulse

	initial begin
		reset = 1'b1;
		av_read = 1'b0;
		av_write = 1'b0;
		av_address = 3'h0;
		av_writedata = 32'h00000000;
		n_fail = 0;
		n_checks = 0;
		void'($urandom(32'h0D96986D));
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		s = $urandom_range(29, 0);
		r = $urandom_range(15, 0);
		r2 = (r + 1) % 16;
		w = $urandom_range(15, 0);
		lk(1'b1, REG_CTRL, 1'b0, 32'h00000000, q, e);
		chk(q, 32'h0000000C);
		lk(1'b1, REG_STATUS, 1'b0, 32'h00000000, q, e);
		chk(q, 32'h00000001);
		av(3'h5, 1'b0, 32'h00000000, q);
		chk(q, 32'h00000000);
		$display("test reset done");
		lk(1'b1, REG_CTRL, 1'b1, {28'h0000000, MODE_PROTECT}, q, e);
		lk(1'b0, wa(s, r, w), 1'b1, 32'hFFFFFFFE, q, e);
		pulse({28'h0000000, MODE_ERASE});
		chk({31'h00000000, e}, 32'h00000000);
		lk(1'b1, REG_STATUS, 1'b0, 32'h00000000, q, e);
		chk(q & 32'h00000001, 32'h00000000);
		lk(1'b0, wa(s, r, w), 1'b0, 32'h00000000, q, e);
		chk({31'h00000000, e}, 32'h00000001);
		wait_ready();
		lk(1'b1, REG_STATUS, 1'b0, 32'h00000000, q, e);
		chk(q, 32'h00000003);
		lk(1'b1, REG_CTRL, 1'b0, 32'h00000000, q, e);
		chk(q, 32'h0000000D);
		lk(1'b1, REG_STATUS, 1'b1, 32'h00000002, q, e);
		lk(1'b1, REG_STATUS, 1'b0, 32'h00000000, q, e);
		chk(q, 32'h00000001);
		lk(1'b1, REG_CTRL, 1'b1, 32'h0000000C, q, e);
		for (i = 0; i < WORDS_PER_ROW; i++) begin
			lk(1'b0, wa(s, r, i), 1'b0, 32'h00000000, q, e);
			chk(q, 32'hFFFFFFFF);
		end
		$display("test erase done");
		lk(1'b1, REG_CTRL, 1'b1, 32'h0000004C, q, e);
		lk(1'b1, REG_CTRL, 1'b1, 32'h00000007, q, e);
		for (i = 0; i < WORDS_PER_ROW; i++) pb[i] = 32'hFFFFFFFF;
		for (i = 0; i < 2; i++) begin
			k = (w + 5 * i) % 16;
			pb[k] = $urandom;
			lk(1'b0, wa(s, r, k), 1'b1, pb[k], q, e);
		end
		pulse({28'h0000000, MODE_PROGRAM});
		wait_ready();
		lk(1'b1, REG_CTRL, 1'b0, 32'h00000000, q, e);
		chk(q, 32'h0000000F);
		lk(1'b1, REG_CTRL, 1'b1, 32'h0000000C, q, e);
		for (i = 0; i < WORDS_PER_ROW; i++) begin
			lk(1'b0, wa(s, r, i), 1'b0, 32'h00000000, q, e);
			chk(q, pb[i]);
		end
		$display("test program done");
		lk(1'b1, REG_CTRL, 1'b1, 32'h00000007, q, e);
		lk(1'b0, wa(s, r2, 0), 1'b1, 32'h00000000, q, e);
		lk(1'b1, REG_CTRL, 1'b1, 32'h00000027, q, e);
		lk(1'b1, REG_CTRL, 1'b0, 32'h00000000, q, e);
		chk(q, 32'h00000007);
		lk(1'b1, REG_CTRL, 1'b1, 32'h0000000C, q, e);
		lk(1'b0, wa(s, r2, 0), 1'b0, 32'h00000000, q, e);
		chk(q, 32'hFFFFFFFF);
		// Program row r2 first so the page erase has zeros to undo
		pulse({28'h0000000, MODE_PROGRAM});
		wait_ready();
		lk(1'b1, REG_CTRL, 1'b1, 32'h0000000C, q, e);
		lk(1'b0, wa(s, r2, 0), 1'b0, 32'h00000000, q, e);
		chk(q, 32'h00000000);
		pulse(32'h00000019);
		wait_ready();
		lk(1'b1, REG_CTRL, 1'b0, 32'h00000000, q, e);
		chk(q, 32'h0000000D);
		lk(1'b1, REG_CTRL, 1'b1, 32'h0000000C, q, e);
		lk(1'b0, wa(s, r2, 0), 1'b0, 32'h00000000, q, e);
		chk(q, 32'hFFFFFFFF);
		lk(1'b0, wa(s, r, w), 1'b0, 32'h00000000, q, e);
		chk(q, pb[w]);
		$display("test page erase done");
		k = (s + 1) % 30;
		lk(1'b1, REG_CTRL, 1'b1, {28'h0000000, MODE_PROTECT}, q, e);
		lk(1'b0, wa(k, 0, 0), 1'b1, 32'hFFFFFFFE, q, e);
		lk(1'b1, REG_CTRL, 1'b1, {28'h0000000, MODE_SELECT}, q, e);
		lk(1'b0, wa(k, 0, 0), 1'b1, 32'h00000000, q, e);
		lk(1'b0, wa(k, 0, 0), 1'b0, 32'h00000000, q, e);
		chk({31'h00000000, e}, 32'h00000001);
		lk(1'b1, REG_CTRL, 1'b1, {28'h0000000, MODE_PROTECT}, q, e);
		lk(1'b0, wa(s, r, w), 1'b1, 32'hFFFFFFFE, q, e);
		pulse({28'h0000000, MODE_ERASE});
		wait_ready();
		lk(1'b1, REG_CTRL, 1'b1, 32'h0000000C, q, e);
		lk(1'b0, wa(k, 0, 0), 1'b0, 32'h00000000, q, e);
		chk(q, 32'hFFFFFFFF);
		lk(1'b0, wa(s, r, w), 1'b0, 32'h00000000, q, e);
		chk(q, 32'hFFFFFFFF);
		$display("test select done");
		tally_and_finish();
	end
endmodule : flash_program_erase_sequencer_tb
